// file: core/stv_consts.svh
`ifndef STV_CONSTS_SVH
`define STV_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (5-bit frame address)
// ---------------------------------------------------------------
`define STV_ADDR_RESULT_A 5'h0d
`define STV_ADDR_RESULT_B 5'h0e

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define STV_RESET_RESULT_A 8'h00
`define STV_RESET_RESULT_B 4'h0

// ---------------------------------------------------------------
// flag positions inside the data byte of result_a
// ---------------------------------------------------------------
`define STV_BIT_LOGIC 7
`define STV_BIT_THERMAL 6
`define STV_BIT_PREREG_OV 5
`define STV_BIT_PREREG_UV 4

// ---------------------------------------------------------------
// frame coding
// ---------------------------------------------------------------
`define STV_FRAME_BITS 5'h10
`define STV_CNT_MAX 5'h1f
`define STV_TYPE_WRITE 1'b1
`define STV_TYPE_READ 1'b0
`define STV_PARITY_GOOD 1'b1

`endif

// file: core/stv_pkg.sv
package stv_pkg;

   // one 16-bit serial frame, msb first on the wire
   typedef struct packed
   {
      logic [4:0] addr;
      logic wr;
      logic spare;
      logic [7:0] data;
      logic par;
   } stv_frame_s;

   typedef enum {STV_IDLE, STV_SHIFT} stv_state_e;

endpackage

// file: core/stv_spi_frame.sv
`timescale 1ns/1ps
`include "stv_consts.svh"

module stv_spi_frame
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // frame side
   input wire stv_pkg::stv_frame_s tx_frame,
   output stv_pkg::stv_frame_s rx_frame,
   output logic frame_done
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // sclk must stay below a quarter of mclk so every edge is seen
   logic sclk_meta, sclk_sync, sclk_prev;
   logic cs_meta, cs_sync, cs_prev;
   logic mosi_meta, mosi_sync;
   logic sclk_rise, sclk_fall;
   stv_pkg::stv_state_e state;
   logic [4:0] bit_cnt;
   logic [15:0] shift_in;
   logic [15:0] shift_out;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         mosi_meta <= 1'b0;
         mosi_sync <= 1'b0;
      end
      else if (clk_en)
      begin
         sclk_meta <= spi_sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         cs_meta <= spi_cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         mosi_meta <= spi_mosi;
         mosi_sync <= mosi_meta;
      end
   end

   assign sclk_rise = sclk_sync & ~sclk_prev;
   assign sclk_fall = ~sclk_sync & sclk_prev;

   // ---------------------------------------------------------------
   // frame shifter
   // ---------------------------------------------------------------
   // only a frame of exactly sixteen clocks is passed on; others are dropped
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state <= stv_pkg::STV_IDLE;
         bit_cnt <= 5'h00;
         shift_in <= 16'h0000;
         shift_out <= 16'h0000;
         rx_frame <= '0;
         frame_done <= 1'b0;
      end
      else if (clk_en)
      begin
         frame_done <= 1'b0;
         case (state)
            stv_pkg::STV_IDLE:
            begin
               if (cs_prev && !cs_sync)
               begin
                  shift_out <= tx_frame;
                  bit_cnt <= 5'h00;
                  state <= stv_pkg::STV_SHIFT;
               end
            end
            default:
            begin
               if (cs_sync)
               begin
                  state <= stv_pkg::STV_IDLE;
                  if (bit_cnt == `STV_FRAME_BITS)
                  begin
                     rx_frame <= stv_pkg::stv_frame_s'(shift_in);
                     frame_done <= 1'b1;
                  end
               end
               else
               begin
                  if (sclk_rise)
                  begin
                     shift_in <= {shift_in[14:0], mosi_sync};
                     if (bit_cnt != `STV_CNT_MAX)
                     begin
                        bit_cnt <= bit_cnt + 5'h01;
                     end
                  end
                  if (sclk_fall)
                  begin
                     shift_out <= {shift_out[14:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // miso drive
   // ---------------------------------------------------------------
   assign spi_miso = shift_out[15];
   assign spi_miso_oe_n = (state != stv_pkg::STV_SHIFT);

endmodule

// file: core/stv_self_test_regs.sv
`timescale 1ns/1ps
`include "stv_consts.svh"

module stv_self_test_regs
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   // serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // self-test failure events
   input wire logic [7:0] fail_a,
   input wire logic [3:0] fail_b,
   // flag state
   output logic [7:0] result_a,
   output logic [3:0] result_b
);

   stv_pkg::stv_frame_s rx;
   stv_pkg::stv_frame_s reply;
   stv_pkg::stv_frame_s next_reply;
   logic frame_done;
   logic parity_ok;
   logic wr_hit_a, wr_hit_b;
   logic [7:0] clr_a;
   logic [3:0] clr_b;
   logic [7:0] next_result_a;
   logic [3:0] next_result_b;

   // ---------------------------------------------------------------
   // serial frame engine
   // ---------------------------------------------------------------
   stv_spi_frame u_frame
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe_n(spi_miso_oe_n),
      .tx_frame(reply),
      .rx_frame(rx),
      .frame_done(frame_done)
   );

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   // a frame with bad parity is never allowed to clear a flag
   assign parity_ok = (^rx) == `STV_PARITY_GOOD;
   assign wr_hit_a = frame_done && parity_ok && (rx.wr == `STV_TYPE_WRITE)
                     && (rx.addr == `STV_ADDR_RESULT_A);
   assign wr_hit_b = frame_done && parity_ok && (rx.wr == `STV_TYPE_WRITE)
                     && (rx.addr == `STV_ADDR_RESULT_B);
   assign clr_a = wr_hit_a ? rx.data : 8'h00;
   assign clr_b = wr_hit_b ? rx.data[3:0] : 4'h0;

   // ---------------------------------------------------------------
   // flags
   // ---------------------------------------------------------------
   // set is or-ed after the clear, so an event in the clearing cycle wins
   assign next_result_a = (result_a & ~clr_a) | fail_a;
   assign next_result_b = (result_b & ~clr_b) | fail_b;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         result_a <= `STV_RESET_RESULT_A;
         result_b <= `STV_RESET_RESULT_B;
      end
      else if (clk_en)
      begin
         result_a <= next_result_a;
         result_b <= next_result_b;
      end
   end

   // ---------------------------------------------------------------
   // reply frame
   // ---------------------------------------------------------------
   // the reply to a frame goes out during the following frame
   always_comb
   begin
      next_reply = '0;
      next_reply.addr = rx.addr;
      next_reply.wr = `STV_TYPE_READ;
      next_reply.spare = ~parity_ok;
      if (rx.addr == `STV_ADDR_RESULT_A)
      begin
         next_reply.data = next_result_a;
      end
      else if (rx.addr == `STV_ADDR_RESULT_B)
      begin
         next_reply.data = {4'h0, next_result_b};
      end
      else
      begin
         next_reply.data = 8'h00;
      end
      next_reply.par = ~(^next_reply[15:1]);
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         reply <= '0;
         reply.par <= `STV_PARITY_GOOD;
      end
      else if (clk_en && frame_done)
      begin
         reply <= next_reply;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   property p_logic_fail;
      clk_en && fail_a[`STV_BIT_LOGIC] |=> result_a[`STV_BIT_LOGIC];
   endproperty
   a_logic_fail: assert property (p_logic_fail) else $error("logic fail flag not set");

   property p_thermal_fail;
      clk_en && fail_a[`STV_BIT_THERMAL] && wr_hit_a |=> result_a[`STV_BIT_THERMAL];
   endproperty
   a_thermal_fail: assert property (p_thermal_fail) else $error("thermal set lost");

   property p_prereg_ov;
      clk_en && fail_a[`STV_BIT_PREREG_OV] ##1 !frame_done [*2]
         |-> result_a[`STV_BIT_PREREG_OV];
   endproperty
   a_prereg_ov: assert property (p_prereg_ov) else $error("prereg ov flag lost");

   property p_prereg_uv;
      clk_en && fail_a[`STV_BIT_PREREG_UV] |=> result_a[`STV_BIT_PREREG_UV]
         && ($rose(result_a[`STV_BIT_PREREG_UV]) || $past(result_a[`STV_BIT_PREREG_UV]));
   endproperty
   a_prereg_uv: assert property (p_prereg_uv) else $error("prereg uv flag not set");

   property p_rail_a;
      clk_en |=> (result_a[3:0] & $past(fail_a[3:0])) == $past(fail_a[3:0]);
   endproperty
   a_rail_a: assert property (p_rail_a) else $error("rail flag a missed");

   property p_rail_b;
      clk_en |=> (result_b & $past(fail_b)) == $past(fail_b);
   endproperty
   a_rail_b: assert property (p_rail_b) else $error("rail flag b missed");

   property p_clear_a;
      clk_en && wr_hit_a && (fail_a == 8'h00) |=>
         result_a == ($past(result_a) & ~$past(rx.data));
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("result_a clear wrong");

   property p_clear_b;
      clk_en && wr_hit_b && (fail_b == 4'h0) |=>
         result_b == ($past(result_b) & ~$past(rx.data[3:0]));
   endproperty
   a_clear_b: assert property (p_clear_b) else $error("result_b clear wrong");

   property p_hold;
      (clk_en && !wr_hit_a && !wr_hit_b) || !clk_en |=>
         (result_a & $past(result_a)) == $past(result_a)
         && (result_b & $past(result_b)) == $past(result_b);
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without clear");

   property p_freeze;
      !clk_en |=> $stable(result_a) && $stable(result_b) && $stable(reply);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

   property p_reply_parity;
      clk_en && frame_done |=> (^reply) == `STV_PARITY_GOOD
         && reply.spare == !$past(parity_ok);
   endproperty
   a_reply_parity: assert property (p_reply_parity) else $error("reply parity bad");

   property p_reply_a;
      clk_en && frame_done && rx.addr == `STV_ADDR_RESULT_A |=> reply.data == result_a;
   endproperty
   a_reply_a: assert property (p_reply_a) else $error("reply a data wrong");

   property p_reply_b;
      clk_en && frame_done && rx.addr == `STV_ADDR_RESULT_B |=>
         reply.data == {4'h0, result_b};
   endproperty
   a_reply_b: assert property (p_reply_b) else $error("reply b data wrong");

   cover property (clk_en && wr_hit_a && (rx.data != 8'h00));
   cover property (clk_en && wr_hit_b && (rx.data[3:0] != 4'h0));
   cover property (clk_en && frame_done && !parity_ok);
   cover property (clk_en && wr_hit_a && ((rx.data & fail_a) != 8'h00));

endmodule

// file: bench/stv_host_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// spi controller in the host's place, mode 0, msb first
// ---------------------------------------------------------------
module stv_host_model
(
   // clock
   input wire logic mclk,
   // serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // halves of 4 mclk keep clear of the device's 2-flop synchronisers
   task automatic xfer(input stv_pkg::stv_frame_s tx, input int nbits,
                       output stv_pkg::stv_frame_s rx);
      logic [15:0] bits;
      logic [15:0] got;
      bits = tx;
      got = 16'h0000;
      spi_cs_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         spi_mosi = bits[i];
         ticks(4);
         got = {got[14:0], spi_miso};
         spi_sclk = 1'b1;
         ticks(4);
         spi_sclk = 1'b0;
      end
      ticks(4);
      spi_cs_n = 1'b1;
      // deselected line shows no stale bit
      spi_mosi = ~spi_mosi;
      ticks(6);
      rx = got;
   endtask
endmodule

// file: bench/self_test_verify_status_regs_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %0t got %h expected %h", $time, got, exp); end end

module self_test_verify_status_regs_bench;
   logic mclk, reset_n, clk_en, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
   logic [7:0] fail_a, result_a;
   logic [3:0] fail_b, result_b;
   int err_count, n_tests;
   stv_pkg::stv_frame_s rx;
   logic miso_line;

   stv_self_test_regs u_stv_self_test_regs (.mclk(mclk), .reset_n(reset_n),
      .clk_en(clk_en), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .fail_a(fail_a),
      .fail_b(fail_b), .result_a(result_a), .result_b(result_b));
   stv_host_model u_stv_host_model (.mclk(mclk), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));

   // a released miso shows the inverse of its last bit, so a late enable spoils the read
   assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // odd parity: xor of all sixteen bits is one; bad flips it
   function automatic stv_pkg::stv_frame_s frame(input logic [4:0] a, input logic w,
                                                 input logic sp, input logic [7:0] d,
                                                 input logic bad);
      frame = {a, w, sp, d, 1'b0};
      frame.par = ~(^frame) ^ bad;
   endfunction

   task automatic send(input logic [4:0] a, input logic w, input logic [7:0] d,
                       input logic bad = 1'b0, input int n = 16);
      u_stv_host_model.xfer(frame(a, w, 1'b0, d, bad), n, rx);
   endtask

   task automatic do_reset;
      reset_n = 1'b0;
      cyc(8);
      reset_n = 1'b1;
      cyc(1);
   endtask

   task report_and_stop;
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values;
      `CHK(result_a, 8'h00)
      `CHK(result_b, 4'h0)
      `CHK(spi_miso_oe_n, 1'b1)
      send(5'h0d, 1'b0, 8'h00);
      send(5'h0e, 1'b0, 8'h00);
      `CHK(rx, frame(5'h0d, 1'b0, 1'b0, 8'h00, 1'b0))
   endtask

   // one event at a time; earlier flags must stay set
   task automatic t_set_flags;
      for (int i = 0; i < 8; i++)
      begin
         fail_a = 8'h01 << i;
         cyc(1);
         fail_a = 8'h00;
         cyc(2);
         `CHK(result_a, 8'((9'h002 << i) - 9'h001))
      end
      for (int i = 0; i < 4; i++)
      begin
         fail_b = 4'h1 << i;
         cyc(1);
         fail_b = 4'h0;
         cyc(2);
         `CHK(result_b, 4'((5'h02 << i) - 5'h01))
      end
      send(5'h0d, 1'b0, 8'h00);
      send(5'h0e, 1'b0, 8'h00);
      `CHK(rx, frame(5'h0d, 1'b0, 1'b0, 8'hff, 1'b0))
      send(5'h0e, 1'b0, 8'h00);
      `CHK(rx, frame(5'h0e, 1'b0, 1'b0, 8'h0f, 1'b0))
   endtask

   // clears, refused frames and replies chained one frame late
   task automatic t_clear;
      send(5'h0d, 1'b1, 8'h81);
      `CHK(result_a, 8'h7e)
      send(5'h0d, 1'b1, 8'h00);
      `CHK(rx, frame(5'h0d, 1'b0, 1'b0, 8'h7e, 1'b0))
      `CHK(result_a, 8'h7e)
      send(5'h0e, 1'b1, 8'hf5);
      `CHK(result_b, 4'ha)
      send(5'h0d, 1'b1, 8'hff, 1'b1);
      `CHK(rx, frame(5'h0e, 1'b0, 1'b0, 8'h0a, 1'b0))
      `CHK(result_a, 8'h7e)
      send(5'h0d, 1'b0, 8'hff);
      `CHK(rx, frame(5'h0d, 1'b0, 1'b1, 8'h7e, 1'b0))
      `CHK(result_a, 8'h7e)
      send(5'h05, 1'b1, 8'hff);
      `CHK({result_a, result_b}, 12'h7ea)
      send(5'h05, 1'b0, 8'h00);
      `CHK(rx, frame(5'h05, 1'b0, 1'b0, 8'h00, 1'b0))
      send(5'h0d, 1'b1, 8'hff, 1'b0, 15);
      `CHK(result_a, 8'h7e)
      send(5'h0d, 1'b1, 8'hff);
      `CHK(rx, frame(5'h05, 1'b0, 1'b0, 8'h00, 1'b0))
      `CHK(result_a, 8'h00)
      send(5'h0e, 1'b1, 8'h0f);
      `CHK(result_b, 4'h0)
   endtask

   // a failure held through a clearing frame survives; events with clk_en low are lost
   task automatic t_set_wins_freeze;
      fail_a = 8'h40;
      send(5'h0d, 1'b1, 8'hff);
      fail_a = 8'h00;
      `CHK(result_a, 8'h40)
      send(5'h0d, 1'b1, 8'h40);
      `CHK(rx, frame(5'h0d, 1'b0, 1'b0, 8'h40, 1'b0))
      `CHK(result_a, 8'h00)
      clk_en = 1'b0;
      fail_a = 8'h01;
      fail_b = 4'h8;
      cyc(2);
      fail_a = 8'h00;
      fail_b = 4'h0;
      clk_en = 1'b1;
      cyc(2);
      `CHK({result_a, result_b}, 12'h000)
   endtask

   task automatic t_reset_clears;
      fail_a = 8'hff;
      fail_b = 4'hf;
      cyc(1);
      fail_a = 8'h00;
      fail_b = 4'h0;
      cyc(1);
      do_reset();
      `CHK({result_a, result_b}, 12'h000)
      send(5'h0e, 1'b0, 8'h00);
      `CHK(rx, frame(5'h00, 1'b0, 1'b0, 8'h00, 1'b0))
   endtask

   initial
   begin
      err_count = 0;
      n_tests = 0;
      clk_en = 1'b1;
      fail_a = 8'h00;
      fail_b = 4'h0;
      do_reset();
      cyc(3);
      t_reset_values();
      t_set_flags();
      t_clear();
      t_set_wins_freeze();
      t_reset_clears();
      report_and_stop();
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end
endmodule
